// ===== include/wide_pixel_consts.vh
// Constants for the wide pixel decode and palette stretch block.
// Assumes byte addresses on a 32-bit classic Wishbone register bus.
`ifndef WIDE_PIXEL_CONSTS_VH
`define WIDE_PIXEL_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL32 8'h00
`define OFS_MODE 8'h04
`define OFS_KEYCTL 8'h08
`define OFS_KEY 8'h0c
`define OFS_KEYMASK 8'h10
`define OFS_PIXMASK 8'h14
`define OFS_PALCTL 8'h18
`define OFS_CTRL24 8'h1c
`define OFS_PALIDX 8'h20
`define OFS_PALDATA 8'h24
`define OFS_STATUS 8'h28

// ****************************************
// Field positions
// ****************************************
`define C32_SPACE 0
`define C32_PATH_LO 1
`define C32_PATH_HI 2
`define C32_SENSE 3
`define C32_OVL 4
`define MODE_FMT24 0
`define MODE_PORT64 1
`define MODE_DBUF 2
`define KEYCTL_BIT0 0
`define PAL_STRETCH_OFF 0
`define PAL_COLOR_RES 1
`define C24_SPACE 0
`define C24_DIRECT 1

// ****************************************
// Path field codes
// ****************************************
`define PATH_INDIRECT 2'h0
`define PATH_DYNAMIC 2'h1
`define PATH_DIRECT 2'h3

// ****************************************
// Reset values
// ****************************************
`define RST_MASK 8'hff
`define RST_ZERO8 8'h00
`define RST_ZERO5 5'h00
`define RST_ZERO3 3'h0
`define RST_ZERO2 2'h0
`define RST_WORD 32'h0000_0000

`endif

// ===== rtl/palette_ram.v
// One 256x8 palette with one write port and two registered read ports.
// Assumes writes and reads share clk_i; read data lag the address by one.
`timescale 1ns/1ps
`default_nettype none
module palette_ram
(
  input wire clk_i,
  input wire we_i,
  input wire [7:0] wr_addr_i,
  input wire [7:0] wr_data_i,
  input wire [7:0] rd_addr_a_i,
  input wire [7:0] rd_addr_b_i,
  output reg [7:0] rd_data_a_o,
  output reg [7:0] rd_data_b_o
);

  reg [7:0] mem [0:255];

  // ****************************************
  // Storage and registered reads
  // ****************************************
  // No reset on the array; contents are undefined until software loads it
  always @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_a_o <= mem[rd_addr_a_i];
    rd_data_b_o <= mem[rd_addr_b_i];
  end

endmodule
`default_nettype wire

// ===== rtl/dac_stretch.v
// Final output register of one colour component toward a DAC.
// Assumes the caller folds resolution, stretch and path into stretch_en_i.
`timescale 1ns/1ps
`default_nettype none
module dac_stretch
(
  input wire clk_i,
  input wire rst_i,
  input wire stretch_en_i,
  input wire [7:0] data_i,
  output reg [7:0] data_o
);

  wire [7:0] data_next;

  // ****************************************
  // Six-bit linear stretch
  // ****************************************
  // Top two bits refill the bottom so 6-bit palettes reach full scale
  assign data_next = stretch_en_i ? {data_i[7:2], data_i[7:6]} : data_i; // R17 R18

  // Output register
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      data_o <= 8'h00;
    end
    else
    begin
      data_o <= data_next;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/wide_pixel_decode.v
// Wide pixel decode: 24 bpp packed and 32 bpp pixels to palettes or DACs,
// keyed overlay, per-pixel bypass and six-bit palette output stretch.
// Assumes a classic Wishbone master and pixels synchronous to clk_i.
//
// Overview of operation
// R1: 24 bpp packed: select bit 1 means YUV
// R2: 32 bpp: one pixel per 32-bit, two per 64-bit
// R3: Key off ignores high byte; on makes it overlay
// R4: Format bit picks RGB or YUV low bytes
// R5: Path 00 through palettes, 11 straight to DACs
// R6: Key off, path 01: per-pixel indirect or direct
// R7: Bit 24/56 controls path; bits above ignored
// R8: Pixel mask applied whether bypassed or not
// R9: Indirect masks and indexes; direct passes unchanged
// R10: Sense 0: control 1 bypasses, 0 looks up
// R11: Sense 1: control 1 looks up, 0 bypasses
// R12: Key match drops high byte, shows underlay
// R13: Mismatch shows overlay; overlay path bit chooses
// R14: Indirect overlay indexes all; direct drives monochrome
// R15: Software avoids indirect overlay with indirect underlay
// R16: Stretch only at 6-bit resolution, indirect path
// R17: Stretch control 0: output bits 7 6 5 4 3 2 7 6
// R18: Stretch control 1: pass palette bits unmodified
// R19: 8-bit resolution: unchanged, stretch control ignored
// R20: Stretch applies to every pixel format
// R21: Key control bit 0 is key enable unless double buffer
// R22: All paths share one fixed pipeline latency
//
// The Wishbone slave port and the address map were left to the implementer.
`include "wide_pixel_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module wide_pixel_decode
(
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire wb_stb_i,
  input wire wb_cyc_i,
  output reg wb_ack_o,
  input wire [63:0] pixel_port_bus_i,
  input wire pixel_valid_i,
  output wire [47:0] dac_data_o,
  output reg [1:0] dac_valid_o,
  output reg [1:0] dac_yuv_o,
  output reg [1:0] dac_overlay_o
);

  // ****************************************
  // Control registers
  // ****************************************
  reg [4:0] ctrl32_reg;
  reg [2:0] mode_reg;
  reg key_ctl_reg;
  reg [7:0] key_reg;
  reg [7:0] key_mask_reg;
  reg [7:0] pix_mask_reg;
  reg [1:0] pal_ctl_reg;
  reg [1:0] ctrl24_reg;
  reg [7:0] pal_index_reg;
  reg [15:0] pixel_count_reg;
  reg [1:0] last_direct_reg;

  // Decoded control fields
  wire component_space_select;
  wire [1:0] wide_pixel_color_path;
  wire bypass_sense_invert;
  wire overlay_color_path;
  wire fmt24;
  wire port64;
  wire dbuf_mode;
  wire overlay_key_match_on;
  wire suppress_second_buffer;
  wire six_bit_stretch_off;
  wire color_resolution_sel;
  wire space24;
  wire direct24;

  // Bus handshake terms
  wire bus_req;
  wire bus_wr;
  wire pal_we;

  // ****************************************
  // Pipeline state
  // ****************************************
  reg [53:0] s1_reg;
  reg [53:0] s1_next;
  reg [1:0] v1_reg;
  reg [1:0] v1_next;
  reg [47:0] d2_reg;
  reg [1:0] dir2_reg;
  reg [1:0] yuv2_reg;
  reg [1:0] ovl2_reg;
  reg [1:0] v2_reg;
  wire [47:0] pal_data;
  wire [1:0] ovl_direct_sel;

  // ****************************************
  // Field decode
  // ****************************************
  assign component_space_select = ctrl32_reg[`C32_SPACE];
  assign wide_pixel_color_path = ctrl32_reg[`C32_PATH_HI:`C32_PATH_LO];
  assign bypass_sense_invert = ctrl32_reg[`C32_SENSE];
  assign overlay_color_path = ctrl32_reg[`C32_OVL];
  assign fmt24 = mode_reg[`MODE_FMT24];
  assign port64 = mode_reg[`MODE_PORT64];
  assign dbuf_mode = mode_reg[`MODE_DBUF];
  assign six_bit_stretch_off = pal_ctl_reg[`PAL_STRETCH_OFF];
  assign color_resolution_sel = pal_ctl_reg[`PAL_COLOR_RES];
  assign space24 = ctrl24_reg[`C24_SPACE];
  assign direct24 = ctrl24_reg[`C24_DIRECT];

  // Bit 0 serves as buffer suppress in double buffer mode only
  assign overlay_key_match_on = key_ctl_reg & ~dbuf_mode; // R21
  assign suppress_second_buffer = key_ctl_reg & dbuf_mode; // R21

  // Unused here; the double buffer path lies outside this block
  assign ovl_direct_sel = {2{suppress_second_buffer}} & 2'b00;

  // ****************************************
  // Address decode
  // ****************************************
  // Word match on a byte offset; low two address bits are ignored
  function hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      hit = (adr[7:2] == ofs[7:2]);
    end
  endfunction

  // A new request is one not yet acknowledged
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  // Palette loads need all three colour lanes
  assign pal_we = bus_wr & hit(wb_adr_i, `OFS_PALDATA) & (&wb_sel_i[2:0]);

  // ****************************************
  // Register writes and palette index
  // ****************************************
  // Single byte lane writes only touch the low byte of each register
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl32_reg <= `RST_ZERO5;
      mode_reg <= `RST_ZERO3;
      key_ctl_reg <= 1'b0;
      key_reg <= `RST_ZERO8;
      key_mask_reg <= `RST_MASK;
      pix_mask_reg <= `RST_MASK;
      pal_ctl_reg <= `RST_ZERO2;
      ctrl24_reg <= `RST_ZERO2;
      pal_index_reg <= `RST_ZERO8;
    end
    else
    begin
      if (bus_wr && hit(wb_adr_i, `OFS_CTRL32))
      begin
        ctrl32_reg <= wb_dat_i[4:0];
      end
      if (bus_wr && hit(wb_adr_i, `OFS_MODE))
      begin
        mode_reg <= wb_dat_i[2:0];
      end
      if (bus_wr && hit(wb_adr_i, `OFS_KEYCTL))
      begin
        key_ctl_reg <= wb_dat_i[`KEYCTL_BIT0];
      end
      if (bus_wr && hit(wb_adr_i, `OFS_KEY))
      begin
        key_reg <= wb_dat_i[7:0];
      end
      if (bus_wr && hit(wb_adr_i, `OFS_KEYMASK))
      begin
        key_mask_reg <= wb_dat_i[7:0];
      end
      if (bus_wr && hit(wb_adr_i, `OFS_PIXMASK))
      begin
        pix_mask_reg <= wb_dat_i[7:0];
      end
      if (bus_wr && hit(wb_adr_i, `OFS_PALCTL))
      begin
        pal_ctl_reg <= wb_dat_i[1:0];
      end
      if (bus_wr && hit(wb_adr_i, `OFS_CTRL24))
      begin
        ctrl24_reg <= wb_dat_i[1:0];
      end
      // Index steps after each entry so a palette loads in one burst
      if (pal_we)
      begin
        pal_index_reg <= pal_index_reg + 8'h01;
      end
      else if (bus_wr && hit(wb_adr_i, `OFS_PALIDX))
      begin
        pal_index_reg <= wb_dat_i[7:0];
      end
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  // Ack one cycle after the request; unmapped words read as zero
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `RST_WORD;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= `RST_WORD;
      if (bus_req && !wb_we_i)
      begin
        if (hit(wb_adr_i, `OFS_CTRL32))
          wb_dat_o <= {27'h000_0000, ctrl32_reg};
        else if (hit(wb_adr_i, `OFS_MODE))
          wb_dat_o <= {29'h0000_0000, mode_reg};
        else if (hit(wb_adr_i, `OFS_KEYCTL))
          wb_dat_o <= {31'h0000_0000, key_ctl_reg};
        else if (hit(wb_adr_i, `OFS_KEY))
          wb_dat_o <= {24'h00_0000, key_reg};
        else if (hit(wb_adr_i, `OFS_KEYMASK))
          wb_dat_o <= {24'h00_0000, key_mask_reg};
        else if (hit(wb_adr_i, `OFS_PIXMASK))
          wb_dat_o <= {24'h00_0000, pix_mask_reg};
        else if (hit(wb_adr_i, `OFS_PALCTL))
          wb_dat_o <= {30'h0000_0000, pal_ctl_reg};
        else if (hit(wb_adr_i, `OFS_CTRL24))
          wb_dat_o <= {30'h0000_0000, ctrl24_reg};
        else if (hit(wb_adr_i, `OFS_PALIDX))
          wb_dat_o <= {24'h00_0000, pal_index_reg};
        else if (hit(wb_adr_i, `OFS_STATUS))
          wb_dat_o <= {14'h0000, last_direct_reg, pixel_count_reg};
        else
          wb_dat_o <= `RST_WORD;
      end
    end
  end

  // ****************************************
  // Pixel decode
  // ****************************************
  // Result: [26] yuv, [25] direct, [24] overlay, [23:0] red green blue
  function [26:0] decode_px;
    input [31:0] px;
    reg [7:0] hb;
    reg [23:0] masked;
    reg key_hit;
    reg bypass;
    begin
      hb = px[31:24];
      masked = px[23:0] & {3{pix_mask_reg}}; // R8 R9
      key_hit = ((hb & key_mask_reg) == (key_reg & key_mask_reg)); // R12
      bypass = px[24] ^ bypass_sense_invert; // R7 R10 R11
      if (fmt24)
      begin
        // YUV leaves this block unmasked for the converter
        if (space24) // R1
          decode_px = {1'b1, 1'b1, 1'b0, px[23:0]};
        else if (direct24)
          decode_px = {1'b0, 1'b1, 1'b0, px[23:0]};
        else
          decode_px = {1'b0, 1'b0, 1'b0, masked};
      end
      else if (overlay_key_match_on && !key_hit) // R3 R13
      begin
        if (overlay_color_path)
          decode_px = {1'b0, 1'b1, 1'b1, {3{hb}}}; // R14
        else
          decode_px = {1'b0, 1'b0, 1'b1, {3{hb & pix_mask_reg}}}; // R14
      end
      else if (component_space_select) // R4
      begin
        decode_px = {1'b1, 1'b1, 1'b0, px[23:0]};
      end
      else
      begin
        case (wide_pixel_color_path)
          `PATH_DIRECT: decode_px = {1'b0, 1'b1, 1'b0, px[23:0]}; // R5
          `PATH_INDIRECT: decode_px = {1'b0, 1'b0, 1'b0, masked}; // R5
          // Per-pixel choice only exists without key matching
          `PATH_DYNAMIC: decode_px = {1'b0,
            bypass & ~overlay_key_match_on, 1'b0, masked}; // R6
          default: decode_px = {1'b0, 1'b0, 1'b0, masked};
        endcase
      end
    end
  endfunction

  // Second lane only carries a pixel on a 64-bit port
  always @*
  begin
    s1_next = {decode_px(pixel_port_bus_i[63:32]),
      decode_px(pixel_port_bus_i[31:0])}; // R2
    v1_next = {pixel_valid_i & port64, pixel_valid_i}; // R2
  end

  // ****************************************
  // Pipeline stages one and two
  // ****************************************
  // Direct data wait one stage so every path has the palette's latency
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg <= 54'h0;
      v1_reg <= 2'b00;
      d2_reg <= 48'h0;
      dir2_reg <= 2'b00;
      yuv2_reg <= 2'b00;
      ovl2_reg <= 2'b00;
      v2_reg <= 2'b00;
    end
    else
    begin
      s1_reg <= s1_next;
      v1_reg <= v1_next;
      d2_reg <= {s1_reg[50:27], s1_reg[23:0]}; // R22
      dir2_reg <= {s1_reg[52], s1_reg[25]} | ovl_direct_sel;
      yuv2_reg <= {s1_reg[53], s1_reg[26]};
      ovl2_reg <= {s1_reg[51], s1_reg[24]};
      v2_reg <= v1_reg;
    end
  end

  // ****************************************
  // Palettes and output stretch
  // ****************************************
  genvar c;
  genvar l;
  generate
    for (c = 0; c < 3; c = c + 1)
    begin : g_pal
      palette_ram u_pal
      (
        .clk_i(clk_i),
        .we_i(pal_we),
        .wr_addr_i(pal_index_reg),
        .wr_data_i(wb_dat_i[8*c+7:8*c]),
        .rd_addr_a_i(s1_reg[8*c+7:8*c]), // R9
        .rd_addr_b_i(s1_reg[27+8*c+7:27+8*c]),
        .rd_data_a_o(pal_data[8*c+7:8*c]),
        .rd_data_b_o(pal_data[24+8*c+7:24+8*c])
      );
    end
    for (l = 0; l < 2; l = l + 1)
    begin : g_lane
      for (c = 0; c < 3; c = c + 1)
      begin : g_col
        // Any format qualifies; only resolution, control and path matter
        dac_stretch u_str
        (
          .clk_i(clk_i),
          .rst_i(rst_i),
          .stretch_en_i(~color_resolution_sel & ~six_bit_stretch_off &
            ~dir2_reg[l]), // R16 R19 R20
          .data_i(dir2_reg[l] ? d2_reg[24*l+8*c+7:24*l+8*c] :
            pal_data[24*l+8*c+7:24*l+8*c]),
          .data_o(dac_data_o[24*l+8*c+7:24*l+8*c])
        );
      end
    end
  endgenerate

  // ****************************************
  // Output flags and status
  // ****************************************
  // Flags ride alongside the stretch stage to stay aligned with data
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dac_valid_o <= 2'b00;
      dac_yuv_o <= 2'b00;
      dac_overlay_o <= 2'b00;
      pixel_count_reg <= 16'h0000;
      last_direct_reg <= 2'b00;
    end
    else
    begin
      dac_valid_o <= v2_reg; // R22
      dac_yuv_o <= yuv2_reg & v2_reg;
      dac_overlay_o <= ovl2_reg & v2_reg;
      // Counter wraps; software reads differences
      pixel_count_reg <= pixel_count_reg + {15'h0000, v2_reg[0]} +
        {15'h0000, v2_reg[1]};
      if (v2_reg[0])
      begin
        last_direct_reg <= dir2_reg & v2_reg;
      end
    end
  end

endmodule
`default_nettype wire

// ===== sim/wide_pixel_checker.sv
// Checker on the top ports of the wide pixel decode block.
// Assumes one clock, synchronous active-high reset, bound by the bind below.
`timescale 1ns/1ps
`default_nettype none
module wide_pixel_checker
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic pixel_valid_i,
  input wire logic [1:0] dac_valid_o,
  input wire logic [1:0] dac_yuv_o,
  input wire logic [1:0] dac_overlay_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0] up_reg;
  // ****
  // Helpers
  // ****
  // Pixel history is trusted only three edges after reset
  always @(posedge clk_i)
    if (rst_i)
      up_reg <= 2'h0;
    else if (up_reg != 2'h3)
      up_reg <= up_reg + 2'h1;
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_s;
    ##1 wb_ack_o;
  endsequence
  // ****
  // Properties
  // ****
  ack_resp_a: assert property (req_s |-> ack_s)
    else $error("request not acknowledged next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  unmap_read_a: assert property
    ((req_s ##0 (!wb_we_i && wb_adr_i >= 8'h2c)) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  pix_latency_a: assert property
    (up_reg == 2'h3 |-> dac_valid_o[0] == $past(pixel_valid_i, 3))
    else $error("lane 0 latency wrong");
  lane_pair_a: assert property (dac_valid_o[1] |-> dac_valid_o[0])
    else $error("lane 1 without lane 0");
  flag_excl_a: assert property ((dac_yuv_o & dac_overlay_o) == 2'h0)
    else $error("overlay flagged as yuv");
  reset_quiet_a: assert property
    ($past(rst_i) |-> !wb_ack_o && dac_valid_o == 2'h0)
    else $error("outputs active after reset");
endmodule
bind wide_pixel_decode wide_pixel_checker chk_u
(
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_adr_i(wb_adr_i),
  .wb_we_i(wb_we_i),
  .wb_stb_i(wb_stb_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o),
  .pixel_valid_i(pixel_valid_i),
  .dac_valid_o(dac_valid_o),
  .dac_yuv_o(dac_yuv_o),
  .dac_overlay_o(dac_overlay_o)
);
`default_nettype wire

// ===== sim/vram_model.sv
// Frame buffer model: random pixel words on the pixel port in bursts.
// Assumes burst_i and slow_i change right after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module vram_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic burst_i,
  input wire logic slow_i,
  output logic [63:0] pix_o = 64'h0000_0000_0000_0000,
  output logic valid_o = 1'b0
);
  integer seed = 32'h0000_1d3b;
  logic [63:0] w;
  // ****
  // Word source
  // ****
  // Idle bus inverts its previous value each cycle, so a long idle alternates two words
  always @(posedge clk_i)
  begin
    w = {$random(seed), $random(seed)};
    w[31:26] = w[2] ? 6'h00 : w[31:26]; // Small bytes hit the key
    w[63:58] = w[3] ? 6'h00 : w[63:58];
    if (rst_i || !burst_i || (slow_i && w[4]))
    begin
      valid_o <= 1'b0;
      pix_o <= ~pix_o;
    end
    else
    begin
      valid_o <= 1'b1;
      pix_o <= w;
    end
  end
endmodule
`default_nettype wire

// ===== sim/wide_pixel_decode_and_palette_stretch_test.sv
// Bench: random configs, pixel bursts and one queue of expected outputs per lane.
// Assumes the design, the checker and the frame buffer model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "wide_pixel_consts.vh"
module wide_pixel_decode_and_palette_stretch_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rd;
  logic [31:0] r;
  logic we = 1'b0;
  logic stb = 1'b0;
  logic cyc = 1'b0;
  logic burst = 1'b0;
  logic slow = 1'b0;
  logic [3:0] sel = 4'h0;
  wire [31:0] rdat;
  wire ack;
  wire pv;
  wire [63:0] pix;
  wire [47:0] dd;
  wire [1:0] dv;
  wire [1:0] dy;
  wire [1:0] dov;
  integer seed = 32'h0000_e5dd;
  integer error_cnt = 0;
  integer n_compared = 0;
  integer n_pix = 0;
  logic [7:0] c32, md, kc, key, km, pm, pc, c24;
  logic [25:0] q0[$];
  logic [25:0] q1[$];
  always #2.5 clk_i = ~clk_i;
  wide_pixel_decode dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel),
    .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(ack),
    .pixel_port_bus_i(pix), .pixel_valid_i(pv), .dac_data_o(dd),
    .dac_valid_o(dv), .dac_yuv_o(dy), .dac_overlay_o(dov));
  vram_model vram_u (.clk_i(clk_i), .rst_i(rst_i), .burst_i(burst),
    .slow_i(slow), .pix_o(pix), .valid_o(pv));
  // ****
  // Expectation
  // ****
  function automatic logic [23:0] lut(input logic [7:0] a, b, c);
    return {a ^ 8'hc3, b + 8'h5d, ~c};
  endfunction
  function automatic logic [23:0] sf(input logic [23:0] c);
    if (pc[1:0] != 2'h0)
      return c;
    return {c[23:18], c[23:22], c[15:10], c[15:14], c[7:2], c[7:6]};
  endfunction
  // Model follows the key, format and path selections of the decoder
  function automatic logic [25:0] xp(input logic [31:0] p);
    logic [7:0] h;
    logic ko, dy_n, d;
    h = p[31:24] & pm;
    ko = kc[0] && !md[0] && !md[2];
    if (ko && ((p[31:24] & km) != (key & km)))
      return {2'b01, c32[4] ? {3{p[31:24]}} : sf(lut(h, h, h))};
    if (md[0] ? c24[0] : c32[0])
      return {2'b10, p[23:0]};
    dy_n = !md[0] && c32[2:1] == 2'h1 && !ko;
    d = md[0] ? c24[1] : (c32[2:1] == 2'h3 || (dy_n && (p[24] ^ c32[3])));
    if (d)
      return {2'b00, dy_n ? p[23:0] & {3{pm}} : p[23:0]};
    return {2'b00, sf(lut(p[23:16] & pm, p[15:8] & pm, p[7:0] & pm))};
  endfunction
  // ****
  // Checks and bus
  // ****
  task automatic print_verdict;
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Held until ack is seen, then released for one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 16)
    begin
      @(posedge clk_i);
      n++;
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n == 16)
    begin
      error_cnt++;
      print_verdict();
    end
    @(posedge clk_i);
  endtask
  // Lanes are compared as {yuv, overlay, data} in arrival order
  always @(posedge clk_i)
  begin
    if (!rst_i && pv === 1'b1)
    begin
      q0.push_back(xp(pix[31:0]));
      n_pix++;
      if (md[1])
      begin
        q1.push_back(xp(pix[63:32]));
        n_pix++;
      end
    end
    if (dv[0] === 1'b1)
      chk({dy[0], dov[0], dd[23:0]}, q0.size() ? q0.pop_front() : '1, "ln0");
    if (dv[1] === 1'b1)
      chk({dy[1], dov[1], dd[47:24]}, q1.size() ? q1.pop_front() : '1, "ln1");
  end
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `OFS_KEYMASK, 32'h0000_0000);
    chk(rd, 32'h0000_00ff, "keymask");
    wb(1'b0, `OFS_PIXMASK, 32'h0000_0000);
    chk(rd, 32'h0000_00ff, "pixmask");
    wb(1'b1, 8'h3c, 32'hffff_ffff);
    wb(1'b0, 8'h3c, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped");
    wb(1'b1, `OFS_PALIDX, 32'h0000_0000);
    for (int i = 0; i < 256; i++)
      wb(1'b1, `OFS_PALDATA, {8'h00, lut(i, i, i)});
    for (int k = 0; k < 24; k++)
    begin
      r = $random(seed);
      c32 = {3'h0, r[4:0]};
      md = {5'h00, r[31], r[6:5]};
      kc = {7'h00, r[7]};
      key = {6'h00, r[9:8]};
      km = r[17:10];
      pm = r[25:18];
      pc = {6'h00, r[27:26]};
      c24 = {6'h00, r[29:28]};
      if (k < 8)
      begin
        c32 = {4'h0, k[2:0], 1'b0};
        kc = 8'h00;
        md = 8'h00;
      end
      if (kc[0] && c32[2:1] != 2'h3 && !c32[0])
        c32[4] = 1'b1;
      wb(1'b1, `OFS_CTRL32, {24'h0, c32});
      wb(1'b1, `OFS_MODE, {24'h0, md});
      wb(1'b1, `OFS_KEYCTL, {24'h0, kc});
      wb(1'b1, `OFS_KEY, {24'h0, key});
      wb(1'b1, `OFS_KEYMASK, {24'h0, km});
      wb(1'b1, `OFS_PIXMASK, {24'h0, pm});
      wb(1'b1, `OFS_PALCTL, {24'h0, pc});
      wb(1'b1, `OFS_CTRL24, {24'h0, c24});
      wb(1'b0, `OFS_CTRL32, 32'h0000_0000);
      chk(rd, {24'h0, c32}, "ctrl32");
      burst <= 1'b1;
      slow <= r[30];
      repeat (32) @(posedge clk_i);
      burst <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk(q0.size() + q1.size(), 32'h0000_0000, "drain");
      // Output pixel counter must match every pixel the bench queued
      wb(1'b0, `OFS_STATUS, 32'h0000_0000);
      chk({16'h0000, rd[15:0]}, {16'h0000, n_pix[15:0]}, "count");
    end
    print_verdict();
  end
endmodule
`default_nettype wire
